// ===== core/keylink_regs.svh
`ifndef KEYLINK_REGS_SVH
`define KEYLINK_REGS_SVH

// transfer address codes
`define ADDR_DISP 8'h41
`define ADDR_CTRL 8'h42
`define ADDR_KEYRD 8'h43

// payload lengths in bits
`define DISP_PAY 6'h39
`define CTRL_PAY 6'h08
`define RD_PAY 6'h1f

// control byte fields
`define CTRL_SEL_LSB 0
`define CTRL_PORT_MODE 2
`define CTRL_PORT_LSB 3
`define CTRL_SCAN_SEG 7
`define CTRL_RST 8'h00

// oscillator model: clock cycles per oscillator period
`define OSC_DIV 6'h14
// key scan timing in oscillator periods
`define SCAN_PERIOD_T 10'h180
`define CONFIRM_T 10'h320
`define RESCAN_T 32'h0000_0640
// oscillator periods per common phase minus one
`define COM_T 4'hf

// link half bit time in clock cycles
`define CL_HALF 4'h8

// host timing
`define CLK_KHZ 32'h0003_0d40
`define DISP_REFRESH_MS 32'h0000_001e
`define DISP_REFRESH_CYC (`DISP_REFRESH_MS * `CLK_KHZ)
`define RESCAN_CYC (`RESCAN_T * 32'(`OSC_DIV))
`define XFER_CYC ((32'h0000_0008 + 32'(`RD_PAY) + 32'h0000_0004) * 32'h0000_0002 * 32'(`CL_HALF))
`define POLL_CYC (`RESCAN_CYC + `XFER_CYC + 32'h0000_0040)
`define IRQ_WAIT_CYC (`RESCAN_CYC + 32'h0000_0040)

`endif

// ===== core/keylink_pkg.sv
package keylink_pkg;

	typedef enum logic [1:0] {
		SCAN_IDLE = 2'b00,
		SCAN_RUN  = 2'b01,
		SCAN_REQ  = 2'b11
	} scan_state_t;

	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_ADDR = 2'b01,
		LINK_PAY  = 2'b11,
		LINK_END  = 2'b10
	} link_state_t;

	typedef logic [54:0] disp_row_t;

endpackage

// ===== core/keylink_if.sv
`timescale 1ns/10ps
`default_nettype none

interface keylink_if;
	logic ce;
	logic cl;
	logic di;
	logic do_oe;
	logic do_line;

	// open-drain data out with pull-up
	assign do_line = !do_oe;

	modport dev (
		input  ce,
		input  cl,
		input  di,
		input  do_line,
		output do_oe
	);

	modport host (
		output ce,
		output cl,
		output di,
		input  do_line
	);
endinterface

`default_nettype wire

// ===== core/key_driver_dev.sv
`include "keylink_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module key_driver_dev
	import keylink_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          external_reset_n,
	input  wire logic [29:0]   key_in,
	keylink_if.dev             link,
	output logic      [48:0]   segment_out,
	output logic      [3:0]    shared_segment_port_out,
	output logic      [1:0]    shared_scan_segment_out,
	output logic      [3:0]    common_out,
	output logic      [2:0]    key_scan_line_mid,
	output logic               key_scan_line_last
);

	// idle scan line levels for each sleep line select
	function automatic logic [5:0] idle_lines(input logic [1:0] sel);
		case (sel)
			2'h0:    idle_lines = 6'h3f;
			2'h1:    idle_lines = 6'h20;
			2'h2:    idle_lines = 6'h30;
			default: idle_lines = 6'h3f;
		endcase
	endfunction

	logic        ce_m, ce_s, ce_d;
	logic        cl_m, cl_s, cl_d;
	logic        di_m, di_s;
	logic        rst_m, rst_s;
	logic [29:0] key_m, key_s;
	logic        in_rst_r;
	logic [5:0]  osc_cnt_r;
	logic        osc_tick;
	logic [7:0]  addr_r;
	logic [3:0]  abit_r;
	logic [56:0] sh_r;
	logic [5:0]  pcnt_r;
	logic [30:0] so_r;
	logic [7:0]  ctrl_r;
	logic        sel_rcvd_r;
	disp_row_t   disp_r [0:3];
	scan_state_t state_r;
	logic [9:0]  tcnt_r;
	logic [29:0] samp_a_r;
	logic [29:0] key_data_r;
	logic        req_r;
	logic        do_oe_r;
	logic [3:0]  com_cnt_r;
	logic [1:0]  phase_r;
	logic        cl_rise, cl_fall, ce_rise, ce_fall;
	logic        rd_act, rd_done;
	logic [5:0]  lines;
	disp_row_t   row;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ce_m  <= 1'b0;
			ce_s  <= 1'b0;
			ce_d  <= 1'b0;
			cl_m  <= 1'b0;
			cl_s  <= 1'b0;
			cl_d  <= 1'b0;
			di_m  <= 1'b0;
			di_s  <= 1'b0;
			rst_m <= 1'b0;
			rst_s <= 1'b0;
			key_m <= 30'h0;
			key_s <= 30'h0;
		end else begin
			ce_m  <= link.ce;
			ce_s  <= ce_m;
			ce_d  <= ce_s;
			cl_m  <= link.cl;
			cl_s  <= cl_m;
			cl_d  <= cl_s;
			di_m  <= link.di;
			di_s  <= di_m;
			rst_m <= external_reset_n;
			rst_s <= rst_m;
			key_m <= key_in;
			key_s <= key_m;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			in_rst_r <= 1'b1;
		end else begin
			in_rst_r <= !rst_s;
		end
	end

	// oscillator period strobe
	always_ff @(posedge clock) begin
		if (sys_rst || osc_cnt_r == `OSC_DIV - 6'h1) begin
			osc_cnt_r <= 6'h0;
		end else begin
			osc_cnt_r <= osc_cnt_r + 6'h1;
		end
	end
	assign osc_tick = (osc_cnt_r == `OSC_DIV - 6'h1);

	assign cl_rise = cl_s && !cl_d;
	assign cl_fall = !cl_s && cl_d;
	assign ce_rise = ce_s && !ce_d;
	assign ce_fall = !ce_s && ce_d;
	assign rd_act  = (addr_r == `ADDR_KEYRD) && (abit_r == 4'h8);
	assign rd_done = ce_fall && rd_act && (pcnt_r != 6'h0);

	// address while ce low, payload while ce high
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			addr_r <= 8'h0;
			abit_r <= 4'h0;
			sh_r   <= 57'h0;
			pcnt_r <= 6'h0;
		end else if (ce_fall) begin
			abit_r <= 4'h0;
			pcnt_r <= 6'h0;
		end else if (cl_rise) begin
			if (!ce_s && abit_r != 4'h8) begin
				addr_r <= {di_s, addr_r[7:1]};
				abit_r <= abit_r + 4'h1;
			end else if (ce_s) begin
				sh_r <= {di_s, sh_r[56:1]};
				if (pcnt_r != 6'h3f) begin
					pcnt_r <= pcnt_r + 6'h1;
				end
			end
		end
	end

	// control and display latch keep loading during pin reset
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_r     <= `CTRL_RST;
			sel_rcvd_r <= 1'b0;
		end else if (ce_fall && abit_r == 4'h8 && addr_r == `ADDR_CTRL && pcnt_r == `CTRL_PAY) begin
			ctrl_r     <= sh_r[56:49];
			sel_rcvd_r <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (ce_fall && abit_r == 4'h8 && addr_r == `ADDR_DISP && pcnt_r == `DISP_PAY) begin
			disp_r[sh_r[56:55]] <= sh_r[54:0];
		end
	end

	// read data: key bits first, sleep ack last
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			so_r <= 31'h0;
		end else if (ce_rise) begin
			so_r <= {ctrl_r[1:0] != 2'h0, key_data_r};
		end else if (cl_fall && ce_s) begin
			so_r <= {1'b0, so_r[30:1]};
		end
	end

	// key scan: two scans must agree
	always_ff @(posedge clock) begin
		if (sys_rst || in_rst_r) begin
			state_r    <= SCAN_IDLE;
			tcnt_r     <= 10'h0;
			samp_a_r   <= 30'h0;
			key_data_r <= 30'h0;
			req_r      <= 1'b0;
		end else begin
			case (state_r)
				SCAN_IDLE: begin
					tcnt_r <= 10'h0;
					if (|key_s) begin
						state_r <= SCAN_RUN;
					end
				end
				SCAN_RUN: begin
					if (osc_tick) begin
						tcnt_r <= tcnt_r + 10'h1;
						if (tcnt_r == `SCAN_PERIOD_T - 10'h1) begin
							samp_a_r <= key_s;
						end
						if (tcnt_r == `CONFIRM_T - 10'h1) begin
							tcnt_r <= 10'h0;
							if (!(|key_s)) begin
								state_r <= SCAN_IDLE;
							end else if (key_s == samp_a_r) begin
								key_data_r <= key_s;
								req_r      <= 1'b1;
								state_r    <= SCAN_REQ;
							end
						end
					end
				end
				SCAN_REQ: begin
					tcnt_r <= 10'h0;
					if (rd_done) begin
						req_r   <= 1'b0;
						state_r <= (|key_s) ? SCAN_RUN : SCAN_IDLE;
					end
				end
				default: begin
					state_r <= SCAN_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || in_rst_r) begin
			do_oe_r <= 1'b0;
		end else if (ce_s) begin
			do_oe_r <= rd_act && !so_r[0];
		end else begin
			do_oe_r <= req_r && !rd_done;
		end
	end
	assign link.do_oe = do_oe_r;

	// 1/4 duty common rotation
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			com_cnt_r <= 4'h0;
			phase_r   <= 2'h0;
		end else if (osc_tick) begin
			com_cnt_r <= (com_cnt_r == `COM_T) ? 4'h0 : com_cnt_r + 4'h1;
			if (com_cnt_r == `COM_T) begin
				phase_r <= phase_r + 2'h1;
			end
		end
	end

	assign lines = idle_lines(ctrl_r[`CTRL_SEL_LSB +: 2]);
	assign row   = disp_r[phase_r];

	always_ff @(posedge clock) begin
		if (sys_rst || in_rst_r) begin
			segment_out             <= 49'h0;
			common_out              <= 4'h0;
			shared_segment_port_out <= 4'h0;
			shared_scan_segment_out <= 2'h0;
			key_scan_line_mid       <= 3'h0;
			key_scan_line_last      <= 1'b1;
		end else begin
			segment_out <= row[52:4];
			common_out  <= 4'h1 << phase_r;
			if (ctrl_r[`CTRL_PORT_MODE]) begin
				shared_segment_port_out <= ctrl_r[`CTRL_PORT_LSB +: 4];
			end else begin
				shared_segment_port_out <= row[3:0];
			end
			if (ctrl_r[`CTRL_SCAN_SEG]) begin
				shared_scan_segment_out <= row[54:53];
			end else begin
				shared_scan_segment_out <= lines[1:0];
			end
			key_scan_line_mid  <= sel_rcvd_r ? lines[4:2] : 3'h0;
			key_scan_line_last <= lines[5];
		end
	end

endmodule

`default_nettype wire

// ===== core/key_ctrl_host.sv
`include "keylink_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module key_ctrl_host
	import keylink_pkg::*;
#(
	parameter int unsigned POLL_CYC     = `POLL_CYC,
	parameter int unsigned IRQ_WAIT_CYC = `IRQ_WAIT_CYC,
	parameter int unsigned REFRESH_CYC  = `DISP_REFRESH_CYC
) (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          irq_mode,
	input  wire logic [219:0]  display_image,
	input  wire logic [7:0]    ctrl_byte,
	keylink_if.host            link,
	output logic      [29:0]   key_data,
	output logic               sleep_ack_bit,
	output logic               key_valid
);

	// job 0 control, 1..4 display rows, 5 key read
	function automatic logic [56:0] pay_of(input logic [2:0] jb);
		case (jb)
			3'h0:    pay_of = {49'h0, ctrl_byte};
			3'h1:    pay_of = {2'h0, display_image[54:0]};
			3'h2:    pay_of = {2'h1, display_image[109:55]};
			3'h3:    pay_of = {2'h2, display_image[164:110]};
			3'h4:    pay_of = {2'h3, display_image[219:165]};
			default: pay_of = 57'h0;
		endcase
	endfunction

	link_state_t st_r;
	logic        do_m, do_s;
	logic [3:0]  hc_r;
	logic        ce_r, cl_r, di_r;
	logic [5:0]  bc_r, plen_r;
	logic [7:0]  ash_r;
	logic [56:0] pay_r;
	logic [30:0] rd_r;
	logic [2:0]  jb_r, rjb_r;
	logic        ref_pend_r;
	logic [22:0] ref_cnt_r, chk_cnt_r;
	logic        poll_due_r;
	logic        key_go, start;
	logic [2:0]  jb_nxt;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			do_m <= 1'b1;
			do_s <= 1'b1;
		end else begin
			do_m <= link.do_line;
			do_s <= do_m;
		end
	end

	assign key_go = irq_mode ? (chk_cnt_r == 23'h0) && !do_s : poll_due_r && !do_s;
	assign start  = (st_r == LINK_IDLE) && (ref_pend_r || key_go);
	assign jb_nxt = ref_pend_r ? rjb_r : 3'h5;

	// full image sent back to back each refresh period
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ref_cnt_r  <= 23'(REFRESH_CYC - 1);
			ref_pend_r <= 1'b1;
			rjb_r      <= 3'h0;
		end else if (ref_cnt_r == 23'h0) begin
			ref_cnt_r  <= 23'(REFRESH_CYC - 1);
			ref_pend_r <= 1'b1;
			rjb_r      <= 3'h0;
		end else begin
			ref_cnt_r <= ref_cnt_r - 23'h1;
			if (start && ref_pend_r) begin
				rjb_r      <= rjb_r + 3'h1;
				ref_pend_r <= (rjb_r != 3'h4);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			chk_cnt_r  <= 23'(POLL_CYC - 1);
			poll_due_r <= 1'b0;
		end else if (irq_mode) begin
			poll_due_r <= 1'b0;
			if (start && !ref_pend_r) begin
				chk_cnt_r <= 23'(IRQ_WAIT_CYC - 1);
			end else if (chk_cnt_r != 23'h0) begin
				chk_cnt_r <= chk_cnt_r - 23'h1;
			end
		end else begin
			chk_cnt_r <= (chk_cnt_r == 23'h0) ? 23'(POLL_CYC - 1) : chk_cnt_r - 23'h1;
			if (chk_cnt_r == 23'h0) begin
				poll_due_r <= 1'b1;
			end else if (st_r == LINK_IDLE && !ref_pend_r) begin
				poll_due_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_r   <= LINK_IDLE;
			hc_r   <= 4'h0;
			ce_r   <= 1'b0;
			cl_r   <= 1'b0;
			di_r   <= 1'b0;
			bc_r   <= 6'h0;
			plen_r <= 6'h0;
			ash_r  <= 8'h0;
			pay_r  <= 57'h0;
			rd_r   <= 31'h0;
			jb_r   <= 3'h0;
		end else begin
			case (st_r)
				LINK_IDLE: begin
					hc_r <= 4'h0;
					bc_r <= 6'h0;
					if (start) begin
						jb_r  <= jb_nxt;
						pay_r <= pay_of(jb_nxt);
						if (jb_nxt == 3'h5) begin
							ash_r  <= `ADDR_KEYRD;
							plen_r <= `RD_PAY;
							di_r   <= 1'(`ADDR_KEYRD & 8'h01);
						end else if (jb_nxt == 3'h0) begin
							ash_r  <= `ADDR_CTRL;
							plen_r <= `CTRL_PAY;
							di_r   <= 1'(`ADDR_CTRL & 8'h01);
						end else begin
							ash_r  <= `ADDR_DISP;
							plen_r <= `DISP_PAY;
							di_r   <= 1'(`ADDR_DISP & 8'h01);
						end
						st_r <= LINK_ADDR;
					end
				end
				LINK_ADDR, LINK_PAY: begin
					hc_r <= (hc_r == `CL_HALF - 4'h1) ? 4'h0 : hc_r + 4'h1;
					if (hc_r == `CL_HALF - 4'h1) begin
						cl_r <= !cl_r;
						if (!cl_r && st_r == LINK_PAY) begin
							rd_r <= {do_s, rd_r[30:1]};
						end
						if (cl_r) begin
							bc_r <= bc_r + 6'h1;
							if (st_r == LINK_ADDR && bc_r == 6'h7) begin
								st_r <= LINK_PAY;
								ce_r <= 1'b1;
								bc_r <= 6'h0;
								di_r <= pay_r[0];
							end else if (st_r == LINK_ADDR) begin
								ash_r <= ash_r >> 1;
								di_r  <= ash_r[1];
							end else if (bc_r == plen_r - 6'h1) begin
								st_r <= LINK_END;
								di_r <= 1'b0;
							end else begin
								pay_r <= pay_r >> 1;
								di_r  <= pay_r[1];
							end
						end
					end
				end
				LINK_END: begin
					hc_r <= hc_r + 4'h1;
					if (hc_r == `CL_HALF - 4'h1) begin
						ce_r <= 1'b0;
						st_r <= LINK_IDLE;
					end
				end
				default: begin
					st_r <= LINK_IDLE;
				end
			endcase
		end
	end

	// reads only start on a low request, so results are valid
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			key_data      <= 30'h0;
			sleep_ack_bit <= 1'b0;
			key_valid     <= 1'b0;
		end else begin
			key_valid <= 1'b0;
			if (st_r == LINK_END && hc_r == `CL_HALF - 4'h1 && jb_r == 3'h5) begin
				key_data      <= rd_r[29:0];
				sleep_ack_bit <= rd_r[30];
				key_valid     <= 1'b1;
			end
		end
	end

	assign link.ce = ce_r;
	assign link.cl = cl_r;
	assign link.di = di_r;

endmodule

`default_nettype wire

// ===== tb/keylink_properties.sv
`timescale 1ns/10ps
`default_nettype none

module keylink_properties (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic cl,
	input wire logic di,
	input wire logic do_oe
);
	logic [7:0] addr_r;
	logic [3:0] acnt_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// address arrives lsb first while ce is low
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			addr_r <= 8'h00;
		end else if (!ce && $rose(cl)) begin
			addr_r <= {di, addr_r[7:1]};
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || ce) begin
			acnt_r <= 4'h0;
		end else if ($rose(cl)) begin
			acnt_r <= acnt_r + 4'h1;
		end
	end

	AST_RST_DO_RELEASED: assert property ($fell(sys_rst) |-> !do_oe [*2])
		else $error("data out driven just after reset");
	AST_CL_HIGH_TIME: assert property ($rose(cl) |-> cl [*8] ##1 !cl)
		else $error("serial clock high time wrong");
	AST_CL_LOW_TIME: assert property ($fell(cl) |-> !cl [*8])
		else $error("serial clock low time too short");
	AST_CE_MOVES_CL_LOW: assert property ($changed(ce) |-> !cl)
		else $error("chip enable moved while clock high");
	AST_DI_STABLE_CL_HIGH: assert property (cl && $past(cl) |-> $stable(di))
		else $error("data in moved while clock high");
	AST_ADDR_EIGHT_BITS: assert property ($rose(ce) |-> acnt_r == 4'h8)
		else $error("address phase not eight bits");
	AST_NO_REQ_IN_WRITE: assert property (ce && $past(ce, 6) && addr_r != 8'h43 |-> !do_oe)
		else $error("request shown during write frame");
	AST_READ_CLEARS_REQ: assert property ($fell(ce) && addr_r == 8'h43 |-> ##8 !do_oe)
		else $error("request not cleared after read");
endmodule

`default_nettype wire

// ===== tb/lcd_driver_reset_and_key_read_tb.sv
`timescale 1ns/10ps
`default_nettype none

`include "keylink_regs.svh"

module lcd_driver_reset_and_key_read_tb;
	localparam int T = int'(`OSC_DIV);
	logic         clock;
	logic         sys_rst;
	logic         external_reset_n;
	logic [29:0]  key_in;
	logic         irq_mode;
	logic [219:0] display_image;
	logic [7:0]   ctrl_byte;
	logic [48:0]  segment_out;
	logic [3:0]   shared_segment_port_out;
	logic [1:0]   shared_scan_segment_out;
	logic [3:0]   common_out;
	logic [2:0]   key_scan_line_mid;
	logic         key_scan_line_last;
	logic [29:0]  key_data;
	logic         sleep_ack_bit;
	logic         key_valid;
	int           mismatches;
	int           n_checks;

	keylink_if link ();

	key_driver_dev u_key_driver_dev (
		.clock(clock), .sys_rst(sys_rst), .external_reset_n(external_reset_n), .key_in(key_in), .link(link),
		.segment_out(segment_out), .shared_segment_port_out(shared_segment_port_out),
		.shared_scan_segment_out(shared_scan_segment_out), .common_out(common_out),
		.key_scan_line_mid(key_scan_line_mid), .key_scan_line_last(key_scan_line_last)
	);

	key_ctrl_host #(.REFRESH_CYC(200000)) u_key_ctrl_host (
		.clock(clock), .sys_rst(sys_rst), .irq_mode(irq_mode), .display_image(display_image),
		.ctrl_byte(ctrl_byte), .link(link), .key_data(key_data), .sleep_ack_bit(sleep_ack_bit), .key_valid(key_valid)
	);

	keylink_properties u_keylink_properties (
		.clock(clock), .sys_rst(sys_rst), .ce(link.ce), .cl(link.cl), .di(link.di), .do_oe(link.do_oe)
	);

	task automatic check_bits(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_span(input string what, input int lo, input int hi, input int got);
		n_checks++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic wait_low(input int limit, output int n);
		n = 0;
		while (link.do_line !== 1'b0 && n < limit) begin
			@(posedge clock);
			n++;
		end
	endtask

	task automatic wait_valid;
		int n;
		n = 0;
		while (key_valid !== 1'b1 && n < 40000) begin
			@(posedge clock);
			n++;
		end
		check_span("read wait", 0, 39999, n);
	endtask

	task automatic check_reset_outputs;
		check_bits("segment_out", 64'h0, 64'(segment_out));
		check_bits("common_out", 64'h0, 64'(common_out));
		check_bits("key_scan_line_last", 64'h1, 64'(key_scan_line_last));
		check_bits("shared_segment_port_out", 64'h0, 64'(shared_segment_port_out));
		check_bits("shared_scan_segment_out", 64'h0, 64'(shared_scan_segment_out));
		check_bits("do_line", 64'h1, 64'(link.do_line));
	endtask

	// control byte: all scan lines idle high, port mode with every port set
	task automatic check_run_outputs;
		check_bits("key_scan_line_mid", 64'h7, 64'(key_scan_line_mid));
		check_bits("key_scan_line_last", 64'h1, 64'(key_scan_line_last));
		check_bits("shared_scan_segment_out", 64'h3, 64'(shared_scan_segment_out));
		check_bits("shared_segment_port_out", 64'hf, 64'(shared_segment_port_out));
		check_bits("segment_out", 64'(display_image[52:4]), 64'(segment_out));
		check_bits("common_out one hot", 64'h1, 64'($onehot(common_out)));
	endtask

	// keys agree on both samples, host polls
	task automatic scenario_agree;
		int n;
		@(posedge clock);
		key_in <= 30'h0000_0201;
		wait_low(900 * T, n);
		check_span("request delay", 800 * T - T, 800 * T + 2 * T, n);
		key_in <= 30'h0000_0000;
		wait_valid;
		check_bits("key_data", 64'h201, 64'(key_data));
		check_bits("sleep_ack_bit", 64'h1, 64'(sleep_ack_bit));
		repeat (20) @(posedge clock);
		check_bits("request cleared", 64'h1, 64'(link.do_line));
	endtask

	// keys change between samples so a rescan is needed, host takes interrupts
	task automatic scenario_rescan;
		int n;
		@(posedge clock);
		irq_mode <= 1'b1;
		key_in <= 30'h0000_0004;
		repeat (500 * T) @(posedge clock);
		key_in <= 30'h2000_0010;
		repeat (350 * T) @(posedge clock);
		check_bits("no early request", 64'h1, 64'(link.do_line));
		wait_low(800 * T, n);
		check_span("rescan delay", 750 * T - T, 750 * T + 2 * T, n);
		key_in <= 30'h0000_0000;
		wait_valid;
		check_bits("key_data", 64'h2000_0010, 64'(key_data));
		check_bits("sleep_ack_bit", 64'h1, 64'(sleep_ack_bit));
	endtask

	// pin reset overrides port configuration
	task automatic scenario_pin_reset;
		@(posedge clock);
		external_reset_n <= 1'b0;
		key_in <= 30'h0000_0001;
		repeat (20) @(posedge clock);
		check_reset_outputs;
		external_reset_n <= 1'b1;
		key_in <= 30'h0000_0000;
		repeat (10) @(posedge clock);
		check_run_outputs;
	endtask

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		repeat (90000) @(posedge clock);
		mismatches++;
		$display("[FAIL] run length expected below 90000 seen 90000");
		give_verdict;
	end

	initial begin
		mismatches = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		external_reset_n = 1'b1;
		key_in = 30'h0000_0000;
		irq_mode = 1'b0;
		display_image = {4{55'h12_3456_789a_bcde}};
		ctrl_byte = 8'h7f;
		repeat (5) @(posedge clock);
		check_reset_outputs;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (6000) @(posedge clock);
		check_run_outputs;
		scenario_agree;
		scenario_rescan;
		scenario_pin_reset;
		give_verdict;
	end
endmodule

`default_nettype wire
